/* dv/test_decrement_skip_and_or_ops.sv */
// Self-checking bench for the dso_exec slice.
// Assumes a 32-entry file model here that answers reads in the same cycle.
module test_decrement_skip_and_or_ops
  import dso_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 0, i_rst = 1, i_insn_valid = 0;
  logic [INSN_W-1:0] i_insn = '0;
  logic [DATA_W-1:0] i_file_rdata, o_acc, fm [32], rf [32];
  logic [DATA_W-1:0] ea = ACC_RESET;
  logic [FIDX_W-1:0] o_file_idx;
  logic o_zero, o_skip_nop, ez = 0, es = 0;
  dso_fwr_t o_file_wr, ew;
  logic [23:0] q [$];
  logic [23:0] n;
  logic [31:0] rs = 32'h3e;
  int n_fail = 0, check_count = 0, pend;

  dso_exec uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_insn_valid(i_insn_valid), .i_insn(i_insn),
    .i_file_rdata(i_file_rdata), .o_file_idx(o_file_idx),
    .o_file_wr(o_file_wr), .o_acc(o_acc), .o_zero(o_zero),
    .o_skip_nop(o_skip_nop));

  // =========================================================
  // Clock, file model and watchdog
  initial forever #20 i_sys_clk = ~i_sys_clk;
  assign i_file_rdata = fm[o_file_idx];
  always @(posedge i_sys_clk)
    if (o_file_wr.en) fm[o_file_wr.idx] <= o_file_wr.data;
  initial begin
    #100000;
    n_fail++;
    close_out();
  end

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic chk(string nm, logic [23:0] e, logic [23:0] s);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // =========================================================
  // Driver: drives one word and notes the expected outcome
  task automatic step(logic v, logic [11:0] w);
    logic [7:0] r;
    logic dec, orl, k;
    @(posedge i_sys_clk);
    #1;
    i_insn_valid = v;
    i_insn = w;
    ew = '0;
    dec = (w[11:6] == OPC_DEC_SKIP);
    orl = (w[11:8] == OPC_OR_LIT);
    k = dec || orl || (w[11:6] == OPC_OR_FILE);
    r = dec ? rf[w[4:0]] - 8'h01 : orl ? ea | w[7:0] : ea | rf[w[4:0]];
    if (v && es) es = 0;
    else if (v && k) begin
      // zero decrement arms skip, zero OR result sets zero flag
      if (dec) es = (r == 8'h00);
      else ez = (r == 8'h00);
      // destination bit picks target, literal to acc
      if (!orl && w[5]) begin
        rf[w[4:0]] = r;
        ew = {1'b1, w[4:0], r};
      end else ea = r;
    end
    q.push_back({ea, ez, es, ew});
  endtask

  // =========================================================
  // Monitor: compares each settled result with the oldest note
  always @(posedge i_sys_clk) begin
    pend = q.size();
    #2;
    if (pend > 0) begin
      n = q.pop_front();
      chk("acc", n[23:16], o_acc);
      chk("zero", n[15], o_zero);
      chk("skip", n[14], o_skip_nop);
      chk("wr_en", n[13], o_file_wr.en);
      if (n[13]) chk("wr", n[12:0], o_file_wr[12:0]);
    end
  end

  // =========================================================
  // Main sequence: directed corner cases, then random words
  initial begin
    for (int i = 0; i < 32; i++) begin
      rs = xs(rs);
      fm[i] = (i == 3) ? 8'h01 : rs[7:0];
      rf[i] = fm[i];
    end
    repeat (2) @(posedge i_sys_clk);
    #1 i_rst = 0;
    chk("reset", {o_acc, o_zero, o_skip_nop, o_file_wr.en}, 24'h0);
    step(1, 12'h2e3);
    step(0, 12'h000);
    step(1, 12'hdff);
    step(1, 12'hd00);
    step(1, 12'h2c3);
    step(1, 12'h103);
    step(1, 12'h123);
    step(1, 12'h103);
    step(1, 12'hd35);
    for (int i = 0; i < 400; i++) begin
      rs = xs(rs);
      case (rs[13:12])
        2'd0: step(rs[16] | rs[17], {OPC_DEC_SKIP, rs[5:0]});
        2'd1: step(rs[16] | rs[17], {OPC_OR_LIT, rs[7:0]});
        2'd2: step(rs[16] | rs[17], {OPC_OR_FILE, rs[5:0]});
        default: step(rs[16] | rs[17], rs[11:0]);
      endcase
    end
    step(0, 12'h000);
    step(0, 12'h000);
    close_out();
  end
endmodule

/* hw/dso_exec.sv */
// Execution slice for decrement-skip, OR-literal and OR-with-file.
// Assumes the register file reads combinationally via o_file_idx and
// that one instruction arrives per cycle, qualified by i_insn_valid.
// A write on o_file_wr may reach the file one edge late; it is forwarded.
// Skip is reported on o_skip_nop; fetch keeps its order and simply
// presents the next valid word, which this slice then discards.
//
// Overview of operation
// RULE1: Decode 0010 11df ffff; decrement file register, flags untouched.
// RULE2: Decrement result goes to accumulator if d=0, file if d=1.
// RULE3: Zero decrement result discards the prefetched next instruction.
// RULE4: Discarded slot runs as a no-op, making two cycles.
// RULE5: Decode 1101 kkkk kkkk; OR accumulator with 8-bit literal.
// RULE6: OR-literal writes accumulator only and updates zero flag.
// RULE7: Decode 0001 00df ffff; OR accumulator with file, d picks target.
// RULE8: Zero flag set when 8-bit result is zero, cleared otherwise.
module dso_exec
  import dso_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_insn_valid,
  input wire logic [INSN_W-1:0] i_insn,
  input wire logic [DATA_W-1:0] i_file_rdata,
  output logic [FIDX_W-1:0] o_file_idx,
  output dso_fwr_t o_file_wr,
  output logic [DATA_W-1:0] o_acc,
  output logic o_zero,
  output logic o_skip_nop
);
  // ==========================================================
  // Decode
  dso_op_t op;
  logic dest_file;
  logic [DATA_W-1:0] lit;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] file_val;
  logic [DATA_W-1:0] acc_reg;
  logic skip_reg;
  logic exec;

  // Index goes straight to the register file for a same-cycle read
  assign o_file_idx = i_insn[FIDX_W-1:0];
  assign dest_file = i_insn[DEST_BIT] != DEST_ACC;
  assign lit = i_insn[DATA_W-1:0];
  // A discarded slot executes nothing
  assign exec = i_insn_valid && !skip_reg;

  // File operand with bypass: o_file_wr lands in the file only at the
  // next edge, so a back-to-back read of that entry would see stale data;
  // the in-flight write wins over the file's own read data
  assign file_val = (o_file_wr.en && o_file_wr.idx == o_file_idx) ?
    o_file_wr.data : i_file_rdata;

  // Opcode match
  always_comb begin
    op = DSO_OP_NONE;
    // RULE1: decrement-skip pattern
    if (i_insn[OPC6_HI:OPC6_LO] == OPC_DEC_SKIP) begin
      op = DSO_OP_DEC_SKIP;
    // RULE7: OR-with-file pattern
    end else if (i_insn[OPC6_HI:OPC6_LO] == OPC_OR_FILE) begin
      op = DSO_OP_OR_FILE;
    // RULE5: OR-literal pattern
    end else if (i_insn[OPC6_HI:OPC4_LO] == OPC_OR_LIT) begin
      op = DSO_OP_OR_LIT;
    end
  end

  // ==========================================================
  // Datapath
  always_comb begin
    case (op)
      // RULE1: subtract one
      DSO_OP_DEC_SKIP: result = file_val - ONE;
      // RULE5: OR with literal
      DSO_OP_OR_LIT: result = acc_reg | lit;
      // RULE7: OR with file
      DSO_OP_OR_FILE: result = acc_reg | file_val;
      default: result = acc_reg;
    endcase
  end

  // ==========================================================
  // Accumulator
  // Decrement with d=0 lands here too; the zero flag is left alone
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      acc_reg <= ACC_RESET;
    // RULE6: literal result into accumulator only
    end else if (exec && op == DSO_OP_OR_LIT) begin
      acc_reg <= result;
    // RULE2: d=0 sends result to accumulator
    end else if (exec && op != DSO_OP_NONE && !dest_file) begin
      acc_reg <= result;
    end
  end
  assign o_acc = acc_reg;

  // File write-back, registered so the port is a flip-flop
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_file_wr <= '0;
    end else begin
      // RULE2: d=1 writes back to file; literal form never does
      o_file_wr.en <= exec && dest_file &&
        (op == DSO_OP_DEC_SKIP || op == DSO_OP_OR_FILE);
      o_file_wr.idx <= i_insn[FIDX_W-1:0];
      o_file_wr.data <= result;
    end
  end

  // Zero flag; decrement leaves it alone
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_zero <= FLAG_RESET;
    // RULE8: flag tracks all-zero result
    end else if (exec && (op == DSO_OP_OR_LIT || op == DSO_OP_OR_FILE)) begin
      o_zero <= (result == ZERO);
    end
  end

  // ==========================================================
  // Skip: the next valid word is squashed into a no-op cycle
  // Idle cycles do not consume the skip: only a valid word does, so
  // a stalled fetch cannot let the discarded instruction slip through
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      skip_reg <= FLAG_RESET;
    // RULE3: zero result arms discard
    end else if (exec && op == DSO_OP_DEC_SKIP) begin
      skip_reg <= (result == ZERO);
    // RULE4: no-op slot consumes the prefetched word
    end else if (i_insn_valid) begin
      skip_reg <= 1'b0;
    end
  end
  assign o_skip_nop = skip_reg;

  // ==========================================================
  // Checks
  // Each property looks one cycle after the taken edge, where the
  // registered results stand; file operands use the forwarded value.
  // RULE3: zero decrement arms skip
  AST_SKIP_ARM: assert property ( // RULE3
    @(posedge i_sys_clk) disable iff (i_rst)
    (exec && op == DSO_OP_DEC_SKIP && file_val == ONE) |=> o_skip_nop)
    else $error("zero decrement did not arm skip");
  // RULE3: nonzero decrement no skip
  AST_SKIP_NONE: assert property ( // RULE3
    @(posedge i_sys_clk) disable iff (i_rst)
    (exec && op == DSO_OP_DEC_SKIP && file_val != ONE) |=> !o_skip_nop)
    else $error("nonzero decrement armed skip");
  // RULE4: squashed slot inert
  AST_NOP_SLOT: assert property ( // RULE4
    @(posedge i_sys_clk) disable iff (i_rst)
    (o_skip_nop && i_insn_valid) |=>
    ($stable(o_acc) && $stable(o_zero) && !o_file_wr.en))
    else $error("discarded slot had an effect");
  // RULE4: squashed slot ends skip
  AST_NOP_DONE: assert property ( // RULE4
    @(posedge i_sys_clk) disable iff (i_rst)
    (o_skip_nop && i_insn_valid) |=> !o_skip_nop)
    else $error("skip outlived the discarded slot");
  // RULE4: skip waits for word
  AST_SKIP_HOLD: assert property ( // RULE4
    @(posedge i_sys_clk) disable iff (i_rst)
    (o_skip_nop && !i_insn_valid) |=> o_skip_nop)
    else $error("skip dropped without a discarded word");
  // RULE1: decrement keeps zero flag
  AST_DEC_NOFLAG: assert property ( // RULE1
    @(posedge i_sys_clk) disable iff (i_rst)
    (exec && op == DSO_OP_DEC_SKIP) |=> $stable(o_zero))
    else $error("decrement altered zero flag");
  // RULE2: decrement to file
  AST_DEC_FILE: assert property ( // RULE2
    @(posedge i_sys_clk) disable iff (i_rst)
    (exec && op == DSO_OP_DEC_SKIP && dest_file) |=>
    (o_file_wr.en && o_file_wr.idx == $past(o_file_idx) &&
    o_file_wr.data == $past(file_val) - ONE))
    else $error("decrement write-back wrong");
  // RULE2: decrement to accumulator
  AST_DEC_ACC: assert property ( // RULE2
    @(posedge i_sys_clk) disable iff (i_rst)
    (exec && op == DSO_OP_DEC_SKIP && !dest_file) |=>
    (o_acc == $past(file_val) - ONE && !o_file_wr.en))
    else $error("decrement to accumulator wrong");
  // RULE5: literal OR result
  AST_OR_LIT: assert property ( // RULE5
    @(posedge i_sys_clk) disable iff (i_rst)
    (exec && op == DSO_OP_OR_LIT) |=>
    (o_acc == ($past(o_acc) | $past(lit))))
    else $error("literal OR wrong");
  // RULE6: literal OR never writes file
  AST_OR_LIT_NOFILE: assert property ( // RULE6
    @(posedge i_sys_clk) disable iff (i_rst)
    (exec && op == DSO_OP_OR_LIT) |=> !o_file_wr.en)
    else $error("literal OR wrote file");
  // RULE8: zero flag after literal
  AST_ZERO_LIT: assert property ( // RULE8
    @(posedge i_sys_clk) disable iff (i_rst)
    (exec && op == DSO_OP_OR_LIT) |=>
    (o_zero == (($past(o_acc) | $past(lit)) == ZERO)))
    else $error("zero flag wrong after literal OR");
  // RULE7: OR with file to accumulator
  AST_OR_FILE: assert property ( // RULE7
    @(posedge i_sys_clk) disable iff (i_rst)
    (exec && op == DSO_OP_OR_FILE && !dest_file) |=>
    (o_acc == ($past(o_acc) | $past(file_val)) && !o_file_wr.en))
    else $error("file OR wrong");
  // RULE7: OR with file to file
  AST_OR_FILE_WR: assert property ( // RULE7
    @(posedge i_sys_clk) disable iff (i_rst)
    (exec && op == DSO_OP_OR_FILE && dest_file) |=>
    (o_file_wr.en && $stable(o_acc) &&
    o_file_wr.data == ($past(o_acc) | $past(file_val))))
    else $error("file OR write-back wrong");
  // RULE8: zero flag follows OR result
  AST_ZERO: assert property ( // RULE8
    @(posedge i_sys_clk) disable iff (i_rst)
    (exec && op == DSO_OP_OR_FILE) |=>
    (o_zero == (($past(o_acc) | $past(file_val)) == ZERO)))
    else $error("zero flag wrong");
endmodule

/* hw/dso_pkg.sv */
// Package for the decrement-skip / OR execution slice.
// Assumes a 12-bit instruction word and an 8-bit data path.
package dso_pkg;
  // ==========================================================
  // Widths
  localparam int DATA_W = 8;
  localparam int INSN_W = 12;
  localparam int FIDX_W = 5;
  // ==========================================================
  // Opcode patterns and field positions
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;   // 0010 11
  localparam logic [5:0] OPC_OR_FILE = 6'h04;    // 0001 00
  localparam logic [3:0] OPC_OR_LIT = 4'hd;      // 1101
  localparam int OPC6_HI = 11;
  localparam int OPC6_LO = 6;
  localparam int OPC4_LO = 8;
  localparam int DEST_BIT = 5;
  localparam logic DEST_ACC = 1'b0;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [7:0] ZERO = 8'h00;

  // Decoded operation kinds
  typedef enum logic [1:0] {
    DSO_OP_NONE = 2'b00,
    DSO_OP_DEC_SKIP = 2'b01,
    DSO_OP_OR_LIT = 2'b10,
    DSO_OP_OR_FILE = 2'b11
  } dso_op_t;

  // Write-back request toward the register file
  typedef struct packed {
    logic en;
    logic [FIDX_W-1:0] idx;
    logic [DATA_W-1:0] data;
  } dso_fwr_t;
endpackage
